//--- tacr_pkg.sv
package tacr_pkg;
   // Register offsets on the device's internal register port
   localparam logic [7:0] CFG_A_OFFSET    = 8'h7c;   // temperature_format_alarm_config
   localparam logic [7:0] CFG_B_OFFSET    = 8'h7d;   // pin_role_fan_attenuator_config
   localparam logic [7:0] CFG_A_RESET     = 8'h01;
   localparam logic [7:0] CFG_B_RESET     = 8'h00;
   // Field positions, temperature_format_alarm_config
   localparam int FORMAT_SELECT_BIT       = 0;
   localparam int OFFSET_RES_BIT          = 1;
   localparam int PROC_ALARM_EN_BIT       = 4;
   localparam int REMOTE_A_ALARM_EN_BIT   = 5;
   localparam int LOCAL_ALARM_EN_BIT      = 6;
   localparam int REMOTE_B_ALARM_EN_BIT   = 7;
   // Field positions, pin_role_fan_attenuator_config
   localparam int PIN_ROLE_LSB            = 0;
   localparam int GLOBAL_KILL_BIT         = 2;
   localparam int FAN_TARGET_BIT          = 3;
   localparam int ATTEN_BYPASS_LSB        = 4;
   localparam int NUM_CHANNELS            = 4;
   localparam int NUM_ATTEN               = 4;
   // Limit codes that switch a channel's alarm off
   localparam logic [7:0] KILL_LIMIT_OFFSET64 = 8'h00;  // -64 C in offset-64 coding
   localparam logic [7:0] KILL_LIMIT_TWOS     = 8'h80;  // -128 C in two's complement
   localparam logic [7:0] TIMER_LIMIT_QUIET   = 8'hff;
   // Shared pin roles
   typedef enum logic [1:0] {
      ROLE_TACH  = 2'h0,
      ROLE_OVERT = 2'h1,
      ROLE_ALERT = 2'h2,
      ROLE_RSVD  = 2'h3
   } tacr_pin_role_type;
endpackage : tacr_pkg

//--- tacr_alarm_chan.sv
`timescale 1ns/1ps
// One sensing channel: compares reading to limit in the selected coding
module tacr_alarm_chan (
   input  wire logic       format_select,
   input  wire logic       enable,
   input  wire logic [7:0] temp_val,
   input  wire logic [7:0] limit_val,
   output logic            exceeded
);
   logic killed;
   logic above;

   // Limit at the coding's bottom value disables the channel
   always_comb begin
      killed = format_select ? (limit_val == tacr_pkg::KILL_LIMIT_TWOS)
                             : (limit_val == tacr_pkg::KILL_LIMIT_OFFSET64);
      // Two's complement compares signed, offset-64 compares unsigned
      above = format_select ? ($signed(temp_val) > $signed(limit_val))
                            : (temp_val > limit_val);
      exceeded = enable && !killed && above;
   end
endmodule : tacr_alarm_chan

//--- tacr_config_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Format bit 1 means two's complement temperatures, 0 means offset-64.
// - Offset resolution 0 gives half-degree steps, 1 gives whole-degree steps.
// - Processor offset is always whole-degree resolution.
// - Processor alarm enable drives pin when above control limit.
// - First remote alarm enable drives pin when above its limit.
// - Local alarm enable drives pin when above local limit.
// - Second remote alarm enable drives pin when above its limit.
// - Limit at -64 (offset-64) or -128 (two's complement) suppresses alarm.
// - Two-bit field picks tachometer, overtemperature or alert pin role.
// - Global kill bit disables overtemperature output on all channels.
// - Overtemperature drives fans full, or to per-fan maximum when selected.
// - Attenuator bypass bits rescale voltage channels to 0 to 2.25 V.
// - Lock bit makes both registers read-only; writes ignored.
module tacr_config_regs (
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   // Register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  config_lock,
   // Readings and limits from the measurement datapath
   input  wire logic [7:0]            proc_temp,
   input  wire logic [7:0]            proc_control_limit,
   input  wire logic [7:0]            remote_a_temp,
   input  wire logic [7:0]            remote_a_limit,
   input  wire logic [7:0]            local_temp,
   input  wire logic [7:0]            local_limit,
   input  wire logic [7:0]            remote_b_temp,
   input  wire logic [7:0]            remote_b_limit,
   input  wire logic                  alert_request,
   // Controls to the rest of the device
   output logic                       format_select,
   output logic                       offset_half_degree,
   output logic                       proc_offset_half_degree,
   output logic [1:0]                 pin_role,
   output logic                       tach_input_select,
   output logic                       fan_override,
   output logic                       fan_use_max_regs,
   output logic [3:0]                 attenuator_bypass,
   // Shared pin, open drain: low while driving
   output logic                       overtemperature_pin_out,
   output logic                       overtemperature_pin_oe_n,
   output logic                       overtemp_event
);
   logic [7:0] cfg_a_reg;
   logic [7:0] cfg_b_reg;
   logic [3:0] chan_enable;
   logic [3:0] chan_exceeded;
   logic [7:0] chan_temp  [4];
   logic [7:0] chan_limit [4];
   logic       any_exceeded;
   logic       overt_drive;
   logic       overt_reg;
   logic       alert_drive;

   // Accepted write to one register; the lock refuses every write
   function automatic logic write_hit(input logic wr, input logic lock, input logic [7:0] addr,
                                      input logic [7:0] target);
      return wr && !lock && (addr == target);
   endfunction : write_hit

   // Writes only while unlocked; lock comes from the config_lock input, not from a config register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_a_reg <= tacr_pkg::CFG_A_RESET;
      end else if (write_hit(reg_wr, config_lock, reg_addr, tacr_pkg::CFG_A_OFFSET)) begin
         cfg_a_reg <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_b_reg <= tacr_pkg::CFG_B_RESET;
      end else if (write_hit(reg_wr, config_lock, reg_addr, tacr_pkg::CFG_B_OFFSET)) begin
         cfg_b_reg <= reg_wdata;
      end
   end

   // Read mux; other addresses belong to neighbours and read zero here
   always_comb begin
      if (reg_addr == tacr_pkg::CFG_A_OFFSET) begin
         reg_rdata = cfg_a_reg;
      end else if (reg_addr == tacr_pkg::CFG_B_OFFSET) begin
         reg_rdata = cfg_b_reg;
      end else begin
         reg_rdata = 8'h00;
      end
   end

   // Decoded controls
   assign format_select           = cfg_a_reg[tacr_pkg::FORMAT_SELECT_BIT];
   assign offset_half_degree      = !cfg_a_reg[tacr_pkg::OFFSET_RES_BIT];
   assign proc_offset_half_degree = 1'h0;
   assign pin_role                = cfg_b_reg[tacr_pkg::PIN_ROLE_LSB +: 2];
   assign tach_input_select       = (pin_role == tacr_pkg::ROLE_TACH);
   assign fan_use_max_regs        = cfg_b_reg[tacr_pkg::FAN_TARGET_BIT];
   assign attenuator_bypass       = cfg_b_reg[tacr_pkg::ATTEN_BYPASS_LSB +: tacr_pkg::NUM_ATTEN];

   // Channel order: processor, remote a, local, remote b
   assign chan_enable = cfg_a_reg[tacr_pkg::REMOTE_B_ALARM_EN_BIT:tacr_pkg::PROC_ALARM_EN_BIT];
   assign chan_temp[0]  = proc_temp;
   assign chan_limit[0] = proc_control_limit;
   assign chan_temp[1]  = remote_a_temp;
   assign chan_limit[1] = remote_a_limit;
   assign chan_temp[2]  = local_temp;
   assign chan_limit[2] = local_limit;
   assign chan_temp[3]  = remote_b_temp;
   assign chan_limit[3] = remote_b_limit;

   // One comparator per channel
   for (genvar i = 0; i < tacr_pkg::NUM_CHANNELS; i++) begin : g_chan
      tacr_alarm_chan u_chan (
         .format_select (format_select),
         .enable        (chan_enable[i]),
         .temp_val      (chan_temp[i]),
         .limit_val     (chan_limit[i]),
         .exceeded      (chan_exceeded[i])
      );
   end

   assign any_exceeded = |chan_exceeded;
   // Fan override follows any exceeding enabled channel, even if the pin is killed
   assign fan_override = any_exceeded;
   assign overt_drive  = (pin_role == tacr_pkg::ROLE_OVERT) &&
                         !cfg_b_reg[tacr_pkg::GLOBAL_KILL_BIT] && any_exceeded;
   assign alert_drive  = (pin_role == tacr_pkg::ROLE_ALERT) && alert_request;

   // Registered pin drive avoids glitches from the comparator tree
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         overt_reg <= 1'h0;
      end else begin
         overt_reg <= overt_drive || alert_drive;
      end
   end

   assign overtemperature_pin_out  = 1'b0;
   assign overtemperature_pin_oe_n = !overt_reg;
   assign overtemp_event           = overt_reg && (pin_role == tacr_pkg::ROLE_OVERT);

   // Assertions
   property p_lock_holds_a;
      @(posedge sys_clk) disable iff (srst)
      config_lock |=> $stable(cfg_a_reg);
   endproperty
   a_lock_holds_a: assert property (p_lock_holds_a) else $error("locked cfg a changed");

   property p_lock_holds_b;
      @(posedge sys_clk) disable iff (srst)
      config_lock |=> $stable(cfg_b_reg);
   endproperty
   a_lock_holds_b: assert property (p_lock_holds_b) else $error("locked cfg b changed");

   property p_write_a;
      @(posedge sys_clk) disable iff (srst)
      write_hit(reg_wr, config_lock, reg_addr, tacr_pkg::CFG_A_OFFSET) |=> (cfg_a_reg == $past(reg_wdata));
   endproperty
   a_write_a: assert property (p_write_a) else $error("cfg a write lost");

   property p_kill_quiet;
      @(posedge sys_clk) disable iff (srst)
      cfg_b_reg[tacr_pkg::GLOBAL_KILL_BIT] && (pin_role == tacr_pkg::ROLE_OVERT) ##1
      cfg_b_reg[tacr_pkg::GLOBAL_KILL_BIT] |-> overtemperature_pin_oe_n;
   endproperty
   a_kill_quiet: assert property (p_kill_quiet) else $error("pin driven while killed");

   sequence s_overt_cause;
      (pin_role == tacr_pkg::ROLE_OVERT) && !cfg_b_reg[tacr_pkg::GLOBAL_KILL_BIT] && any_exceeded;
   endsequence
   property p_overt_drive;
      @(posedge sys_clk) disable iff (srst)
      s_overt_cause |=> !overtemperature_pin_oe_n;
   endproperty
   a_overt_drive: assert property (p_overt_drive) else $error("pin not driven on alarm");

   property p_tach_quiet;
      @(posedge sys_clk) disable iff (srst)
      (pin_role == tacr_pkg::ROLE_TACH) ##1 (pin_role == tacr_pkg::ROLE_TACH) |-> overtemperature_pin_oe_n;
   endproperty
   a_tach_quiet: assert property (p_tach_quiet) else $error("pin driven in tach role");

   property p_proc_enable;
      @(posedge sys_clk) disable iff (srst)
      !cfg_a_reg[tacr_pkg::PROC_ALARM_EN_BIT] |-> !chan_exceeded[0];
   endproperty
   a_proc_enable: assert property (p_proc_enable) else $error("disabled processor alarm");

   property p_remote_a_enable;
      @(posedge sys_clk) disable iff (srst)
      !cfg_a_reg[tacr_pkg::REMOTE_A_ALARM_EN_BIT] |-> !chan_exceeded[1];
   endproperty
   a_remote_a_enable: assert property (p_remote_a_enable) else $error("disabled remote a alarm");

   property p_local_enable;
      @(posedge sys_clk) disable iff (srst)
      !cfg_a_reg[tacr_pkg::LOCAL_ALARM_EN_BIT] |-> !chan_exceeded[2];
   endproperty
   a_local_enable: assert property (p_local_enable) else $error("disabled local alarm");

   property p_remote_b_enable;
      @(posedge sys_clk) disable iff (srst)
      !cfg_a_reg[tacr_pkg::REMOTE_B_ALARM_EN_BIT] |-> !chan_exceeded[3];
   endproperty
   a_remote_b_enable: assert property (p_remote_b_enable) else $error("disabled remote b alarm");

   property p_kill_limit;
      @(posedge sys_clk) disable iff (srst)
      (format_select && local_limit == tacr_pkg::KILL_LIMIT_TWOS) |-> !chan_exceeded[2];
   endproperty
   a_kill_limit: assert property (p_kill_limit) else $error("killed limit still alarms");

   property p_write_b;
      @(posedge sys_clk) disable iff (srst)
      write_hit(reg_wr, config_lock, reg_addr, tacr_pkg::CFG_B_OFFSET) |=> (cfg_b_reg == $past(reg_wdata));
   endproperty
   a_write_b: assert property (p_write_b) else $error("cfg b write lost");

   property p_alert_drive;
      @(posedge sys_clk) disable iff (srst)
      (pin_role == tacr_pkg::ROLE_ALERT) && alert_request |=> !overtemperature_pin_oe_n;
   endproperty
   a_alert_drive: assert property (p_alert_drive) else $error("pin not driven on alert");

   // Reset must win over the lock and release the pin
   property p_reset_values;
      @(posedge sys_clk)
      srst |=> (cfg_a_reg == tacr_pkg::CFG_A_RESET) && (cfg_b_reg == tacr_pkg::CFG_B_RESET) &&
               overtemperature_pin_oe_n;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values not restored");
endmodule : tacr_config_regs

//--- tacr_host_model.sv
`timescale 1ns/1ps
// Host software side of the register port, one access at a time
module tacr_host_model (
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata
);
   // Bus idle at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'h0;
      reg_wdata = 8'h00;
   end

   // One-cycle write strobe; address and data held until the taking edge
   task write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'h0;
      reg_wdata = ~d;  // Released data must not look valid
   endtask : write

   // Read data is combinational, so only the address moves
   task read_addr(input logic [7:0] a);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
   endtask : read_addr
endmodule : tacr_host_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   typedef struct {int id; logic [7:0] exp;} tacr_note_type;
   logic          sys_clk, reg_wr, config_lock, alert_request, format_select, offset_half_degree;
   logic          proc_offset_half_degree, tach_input_select, fan_override, fan_use_max_regs;
   logic          overtemperature_pin_out, overtemperature_pin_oe_n, overtemp_event, chk, any;
   logic          srst = 1'h1;
   logic [7:0]    reg_addr, reg_wdata, reg_rdata, a, b, x;
   logic [7:0]    temp [4];
   logic [7:0]    lim [4];
   logic [1:0]    pin_role;
   logic [3:0]    attenuator_bypass;
   logic [31:0]   seed = 32'h284cfb22;
   int            miscompares = 0;
   int            n_compared = 0;
   tacr_note_type q [$];

   tacr_host_model host (.sys_clk, .reg_addr, .reg_wr, .reg_wdata);
   tacr_config_regs dut (.sys_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .config_lock,
      .proc_temp(temp[0]), .proc_control_limit(lim[0]), .remote_a_temp(temp[1]),
      .remote_a_limit(lim[1]), .local_temp(temp[2]), .local_limit(lim[2]),
      .remote_b_temp(temp[3]), .remote_b_limit(lim[3]), .alert_request, .format_select,
      .offset_half_degree, .proc_offset_half_degree, .pin_role, .tach_input_select,
      .fan_override, .fan_use_max_regs, .attenuator_bypass, .overtemperature_pin_out,
      .overtemperature_pin_oe_n, .overtemp_event);

   // 125 MHz clock
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   // Channel over its limit in the chosen coding, unless the limit is the kill code
   function automatic logic hot(input logic [7:0] t, input logic [7:0] l, input logic tw);
      return (tw ? $signed(t) > $signed(l) : t > l)
         && l != (tw ? tacr_pkg::KILL_LIMIT_TWOS : tacr_pkg::KILL_LIMIT_OFFSET64);
   endfunction : hot

   // Outputs grouped into bytes so one queue serves every check
   function automatic logic [7:0] obs(input int id);
      case (id)
         0: return reg_rdata;
         1: return {format_select, offset_half_degree, proc_offset_half_degree, tach_input_select,
            fan_override, fan_use_max_regs, pin_role};
         2: return {4'h0, attenuator_bypass};
         default: return {5'h0, overtemperature_pin_oe_n, overtemperature_pin_out, overtemp_event};
      endcase
   endfunction : obs

   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Note the expectation, then flag the monitor for one cycle
   task expect_out(input int id, input logic [7:0] e);
      q.push_back('{id, e});
      @(posedge sys_clk);
      #1 chk = 1'h1;
      @(posedge sys_clk);
      #1 chk = 1'h0;
   endtask : expect_out

   // Monitor samples mid-cycle, well clear of the launching edge
   always @(negedge sys_clk) begin
      tacr_note_type n;
      if (chk === 1'h1 && q.size() > 0) begin
         n = q.pop_front();
         check($sformatf("output group %0d", n.id), obs(n.id), n.exp);
      end
   end

   // Pin is registered, so let two edges pass before judging it
   task automatic check_all(input logic [7:0] ca, input logic [7:0] cb);
      logic pin;
      repeat (2) @(posedge sys_clk);
      any = 1'h0;
      for (int i = 0; i < 4; i++) any |= ca[4+i] && hot(temp[i], lim[i], ca[0]);
      pin = (cb[1:0] == 2'h1 && !cb[2] && any) || (cb[1:0] == 2'h2 && alert_request);
      expect_out(1, {ca[0], ~ca[1], 1'h0, cb[1:0] == 2'h0, any, cb[3], cb[1:0]});
      expect_out(2, {4'h0, cb[7:4]});
      expect_out(3, {5'h0, ~pin, 1'h0, pin && cb[1:0] == 2'h1});
   endtask : check_all

   task report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // Whole run is under a thousand cycles; this allows twenty times that
   initial begin
      #160000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      chk = 1'h0;
      config_lock = 1'h0;
      alert_request = 1'h0;
      for (int i = 0; i < 4; i++) {temp[i], lim[i]} = 16'h0000;
      repeat (12) @(posedge sys_clk);
      #1 srst = 1'h0;
      host.read_addr(tacr_pkg::CFG_A_OFFSET);
      expect_out(0, 8'h01);
      host.read_addr(tacr_pkg::CFG_B_OFFSET);
      expect_out(0, 8'h00);
      check_all(8'h01, 8'h00);
      // Timer limit lives outside this block, so this write must land nowhere
      host.write(8'h7a, tacr_pkg::TIMER_LIMIT_QUIET);
      host.read_addr(8'h7a);
      expect_out(0, 8'h00);
      // Random configurations, readings and limits
      repeat (40) begin
         a = rnd();
         b = rnd();
         host.write(tacr_pkg::CFG_A_OFFSET, a);
         host.write(tacr_pkg::CFG_B_OFFSET, b);
         for (int i = 0; i < 4; i++) {temp[i], lim[i]} = {rnd(), rnd()};
         x = rnd();
         alert_request = x[0];
         host.read_addr(tacr_pkg::CFG_A_OFFSET);
         expect_out(0, a);
         check_all(a, b);
      end
      // Kill codes per coding; channel 0 differs only by signedness
      for (int k = 0; k < 2; k++) begin
         a = {4'hf, 3'h0, k[0]};
         b = 8'h01;
         host.write(tacr_pkg::CFG_A_OFFSET, a);
         host.write(tacr_pkg::CFG_B_OFFSET, b);
         for (int i = 1; i < 4; i++) {temp[i], lim[i]} = {8'h7f, k[0] ? 8'h80 : 8'h00};
         {temp[0], lim[0]} = 16'h10f0;
         check_all(a, b);
      end
      // Locked: writes to either register are dropped
      config_lock = 1'h1;
      host.write(tacr_pkg::CFG_A_OFFSET, ~a);
      host.write(tacr_pkg::CFG_B_OFFSET, ~b);
      host.read_addr(tacr_pkg::CFG_A_OFFSET);
      expect_out(0, a);
      host.read_addr(tacr_pkg::CFG_B_OFFSET);
      expect_out(0, b);
      check_all(a, b);
      // Mid-run reset restores power-on values even while locked
      srst = 1'h1;
      repeat (2) @(posedge sys_clk);
      #1 srst = 1'h0;
      host.read_addr(tacr_pkg::CFG_A_OFFSET);
      expect_out(0, tacr_pkg::CFG_A_RESET);
      host.read_addr(tacr_pkg::CFG_B_OFFSET);
      expect_out(0, tacr_pkg::CFG_B_RESET);
      check_all(tacr_pkg::CFG_A_RESET, tacr_pkg::CFG_B_RESET);
      report_and_stop();
   end
endmodule : testbench
